// >>> src/pcs_pkg.sv
package pcs_pkg;
  localparam int PC_W = 15;
  localparam int SP_W = 5;
  localparam int STK_DEPTH = 16;
  localparam int STK_AW = 4;
  localparam int LATCH_W = 7;
  localparam int CALL_W = 11;
  localparam int BRA_W = 9;
  localparam logic [14:0] PC_RESET = 15'h0000;
  localparam logic [6:0] LATCH_RESET = 7'h00;
  localparam logic [4:0] SP_RESET = 5'h1f;
  localparam logic [4:0] SP_LAST = 5'h0f;
  localparam logic [4:0] SP_EMPTY = 5'h1f;
  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_STATUS = 12'hfe0;
  localparam logic [11:0] IDX_CONFIG = 12'hfe1;
  localparam logic [11:0] IDX_PC_LOW = 12'hfe2;
  localparam logic [11:0] IDX_PC_LATCH = 12'hfe3;
  localparam logic [11:0] IDX_STACK_POINTER = 12'hfed;
  localparam logic [11:0] IDX_TOS_LOW = 12'hfee;
  localparam logic [11:0] IDX_TOS_HIGH = 12'hfef;
  localparam int BUS_AW = 14;
  localparam int STAT_OVF_BIT = 0;
  localparam int STAT_UNF_BIT = 1;
  localparam int CFG_FAULT_EN_BIT = 0;
  localparam logic CFG_FAULT_EN_RESET = 1'b0;

  typedef enum logic [7:0] {
    PCS_OP_NONE = 8'h00,
    PCS_OP_STEP = 8'h01,
    PCS_OP_PCL_WRITE = 8'h02,
    PCS_OP_CALL = 8'h04,
    PCS_OP_CALL_VIA_WORKING = 8'h08,
    PCS_OP_BRANCH_RELATIVE_WORKING = 8'h10,
    PCS_OP_BRANCH_RELATIVE_LITERAL = 8'h20,
    PCS_OP_RETURN = 8'h40,
    PCS_OP_INTERRUPT = 8'h80
  } pcs_op_t;

  typedef enum logic [1:0] {
    PCS_BUS_IDLE = 2'b01,
    PCS_BUS_ACK = 2'b10
  } pcs_bus_state_t;

  function automatic logic [11:0] pcs_index(input logic [13:0] byte_addr);
    pcs_index = byte_addr[13:2];
  endfunction : pcs_index
endpackage : pcs_pkg

// >>> src/pcs_stack_mem.sv
`timescale 1ns/1ps
module pcs_stack_mem #(
  parameter int DEPTH = pcs_pkg::STK_DEPTH,
  parameter int WIDTH = pcs_pkg::PC_W,
  parameter int AW = pcs_pkg::STK_AW
) (
  // clocking
  input wire logic clock,
  input wire logic reset,
  input wire logic ce,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // read port, address is the next pointer value
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem_q [DEPTH];

  // separate storage from program and data memory
  always_ff @(posedge clock) begin
    if (ce && we) begin
      mem_q[waddr] <= wdata;
    end
  end

  // write-through so the top entry is valid the cycle after any push or edit
  always_ff @(posedge clock) begin
    if (reset) begin
      rdata <= '0;
    end else if (ce) begin
      if (we && (waddr == raddr)) begin
        rdata <= wdata;
      end else begin
        rdata <= mem_q[raddr];
      end
    end
  end
endmodule : pcs_stack_mem

// >>> src/pcs_avmm_port.sv
`timescale 1ns/1ps
module pcs_avmm_port (
  // clocking
  input wire logic clock,
  input wire logic reset,
  input wire logic ce,
  // avalon-mm slave side
  input wire logic avs_read,
  input wire logic avs_write,
  output logic avs_waitrequest,
  output logic [31:0] avs_readdata,
  // register side
  input wire logic [31:0] reg_rdata,
  output logic reg_wr_fire
);
  pcs_pkg::pcs_bus_state_t state_q;
  logic req;

  assign req = avs_read | avs_write;
  // every access waits exactly one cycle so read data can come from a flop
  assign avs_waitrequest = req & (state_q != pcs_pkg::PCS_BUS_ACK);
  assign reg_wr_fire = avs_write & (state_q == pcs_pkg::PCS_BUS_ACK) & ce;

  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= pcs_pkg::PCS_BUS_IDLE;
    end else if (ce) begin
      case (state_q)
        pcs_pkg::PCS_BUS_IDLE: begin
          if (req) begin
            state_q <= pcs_pkg::PCS_BUS_ACK;
          end
        end
        pcs_pkg::PCS_BUS_ACK: state_q <= pcs_pkg::PCS_BUS_IDLE;
        default: state_q <= pcs_pkg::PCS_BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      avs_readdata <= '0;
    end else if (ce && avs_read && (state_q == pcs_pkg::PCS_BUS_IDLE)) begin
      avs_readdata <= reg_rdata;
    end
  end
endmodule : pcs_avmm_port

// >>> src/pcs_core.sv
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
module pcs_core #(
  parameter logic [14:0] INT_VECTOR = 15'h0004
) (
  // clocking and reset
  input wire logic clock,
  input wire logic reset,
  input wire logic ce,
  input wire logic power_on_reset,
  // core execution side
  input wire pcs_pkg::pcs_op_t op,
  input wire logic [10:0] op_operand,
  input wire logic [7:0] working,
  input wire logic [7:0] pcl_wdata,
  input wire logic latch_we,
  input wire logic [6:0] latch_wdata,
  // core-facing state
  output logic [14:0] pc,
  output logic [6:0] pc_high_latch,
  output logic [4:0] stack_pointer,
  output logic stack_overflow_flag,
  output logic stack_underflow_flag,
  output logic stack_fault_reset,
  // avalon-mm register port
  input wire logic [13:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  ////////////////////////////////////////////////////////////////////////////////
  logic [14:0] pc_q;
  logic [14:0] pc_d;
  logic [6:0] latch_q;
  logic [4:0] sp_q;
  logic [4:0] sp_d;
  logic ovf_q;
  logic unf_q;
  logic fault_en_q;
  logic fault_q;
  logic [14:0] tos;
  logic [14:0] pc_inc;
  logic [14:0] push_val;
  logic stk_we;
  logic [3:0] stk_waddr;
  logic [14:0] stk_wdata;
  logic push;
  logic pop;
  logic ovf_evt;
  logic unf_evt;
  logic wr_fire;
  logic wr_lane;
  logic [11:0] idx;
  logic [31:0] reg_rdata;

  function automatic logic is_push(input pcs_pkg::pcs_op_t o);
    is_push = (o == pcs_pkg::PCS_OP_CALL) || (o == pcs_pkg::PCS_OP_CALL_VIA_WORKING) ||
              (o == pcs_pkg::PCS_OP_INTERRUPT);
  endfunction : is_push

  function automatic logic is_hit(input logic [11:0] a, input logic [11:0] b);
    is_hit = (a == b);
  endfunction : is_hit

  ////////////////////////////////////////////////////////////////////////////////
  assign idx = pcs_pkg::pcs_index(avs_address);
  // only the low byte lane carries register data
  assign wr_lane = wr_fire & avs_byteenable[0];
  assign push = is_push(op);
  assign pop = (op == pcs_pkg::PCS_OP_RETURN);
  assign pc_inc = pc_q + 15'h0001;
  // interrupts resume at the interrupted address, calls after the call
  assign push_val = (op == pcs_pkg::PCS_OP_INTERRUPT) ? pc_q : pc_inc;
  assign ovf_evt = push && (sp_q == pcs_pkg::SP_LAST);
  assign unf_evt = pop && (sp_q == pcs_pkg::SP_EMPTY);

  ////////////////////////////////////////////////////////////////////////////////
  // next program counter
  always_comb begin
    pc_d = pc_q;
    case (op)
      pcs_pkg::PCS_OP_STEP: pc_d = pc_inc;
      pcs_pkg::PCS_OP_PCL_WRITE: pc_d = {latch_q, pcl_wdata};
      pcs_pkg::PCS_OP_CALL: pc_d = {latch_q[6:3], op_operand};
      pcs_pkg::PCS_OP_CALL_VIA_WORKING: pc_d = {latch_q, working};
      pcs_pkg::PCS_OP_BRANCH_RELATIVE_WORKING: begin
        pc_d = pc_inc + {7'h00, working};
      end
      pcs_pkg::PCS_OP_BRANCH_RELATIVE_LITERAL: begin
        // free page crossing: full 15-bit add
        pc_d = pc_inc + {{6{op_operand[8]}}, op_operand[8:0]};
      end
      pcs_pkg::PCS_OP_RETURN: pc_d = tos; // read entry before decrement
      pcs_pkg::PCS_OP_INTERRUPT: pc_d = INT_VECTOR;
      default: pc_d = pc_q;
    endcase
    if (!push && !pop && (op == pcs_pkg::PCS_OP_NONE) && wr_lane &&
        is_hit(idx, pcs_pkg::IDX_PC_LOW)) begin
      pc_d = {latch_q, avs_writedata[7:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next stack pointer and stack writes; core traffic beats bus edits
  always_comb begin
    sp_d = sp_q;
    stk_we = 1'b0;
    stk_waddr = sp_q[3:0];
    stk_wdata = tos;
    if (push) begin
      sp_d = sp_q + 5'h01; // increment then write
      stk_we = 1'b1;
      stk_waddr = sp_d[3:0]; // low four bits wrap the ring
      stk_wdata = push_val;
    end else if (pop) begin
      sp_d = sp_q - 5'h01;
    end else if (wr_lane && is_hit(idx, pcs_pkg::IDX_STACK_POINTER)) begin
      // an interrupt push in the same cycle would win here
      sp_d = avs_writedata[4:0];
    end else if (wr_lane && is_hit(idx, pcs_pkg::IDX_TOS_LOW)) begin
      stk_we = 1'b1;
      stk_wdata = {tos[14:8], avs_writedata[7:0]};
    end else if (wr_lane && is_hit(idx, pcs_pkg::IDX_TOS_HIGH)) begin
      stk_we = 1'b1;
      stk_wdata = {avs_writedata[6:0], tos[7:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock) begin
    if (reset) begin
      pc_q <= pcs_pkg::PC_RESET;
    end else if (ce) begin
      pc_q <= pc_d;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      sp_q <= pcs_pkg::SP_RESET;
    end else if (ce) begin
      sp_q <= sp_d;
    end
  end

  // latch is written only by the core or the bus, never by stack traffic
  always_ff @(posedge clock) begin
    if (reset) begin
      latch_q <= pcs_pkg::LATCH_RESET;
    end else if (ce) begin
      if (latch_we) begin
        latch_q <= latch_wdata;
      end else if (wr_lane && is_hit(idx, pcs_pkg::IDX_PC_LATCH)) begin
        latch_q <= avs_writedata[6:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      fault_en_q <= pcs_pkg::CFG_FAULT_EN_RESET;
    end else if (ce && wr_lane && is_hit(idx, pcs_pkg::IDX_CONFIG)) begin
      fault_en_q <= avs_writedata[pcs_pkg::CFG_FAULT_EN_BIT];
    end
  end

  // flags survive a fault reset so software can see why; set beats clear
  // a reset that is not a power-on only holds them, so stray ops during it set nothing
  always_ff @(posedge clock) begin
    if (reset && power_on_reset) begin
      ovf_q <= 1'b0;
      unf_q <= 1'b0;
    end else if (ce && !reset) begin
      if (ovf_evt) begin
        ovf_q <= 1'b1;
      end else if (wr_lane && is_hit(idx, pcs_pkg::IDX_STATUS) &&
                   avs_writedata[pcs_pkg::STAT_OVF_BIT]) begin
        ovf_q <= 1'b0;
      end
      if (unf_evt) begin
        unf_q <= 1'b1;
      end else if (wr_lane && is_hit(idx, pcs_pkg::IDX_STATUS) &&
                   avs_writedata[pcs_pkg::STAT_UNF_BIT]) begin
        unf_q <= 1'b0;
      end
    end
  end

  // one-cycle reset request toward the system reset logic
  always_ff @(posedge clock) begin
    if (reset) begin
      fault_q <= 1'b0;
    end else if (ce) begin
      fault_q <= fault_en_q && (ovf_evt || unf_evt);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register read mux; reserved bits read as zero
  always_comb begin
    reg_rdata = 32'h0000_0000;
    case (idx)
      pcs_pkg::IDX_STATUS: reg_rdata = {30'h0000_0000, unf_q, ovf_q};
      pcs_pkg::IDX_CONFIG: reg_rdata = {31'h0000_0000, fault_en_q};
      pcs_pkg::IDX_PC_LOW: reg_rdata = {24'h00_0000, pc_q[7:0]};
      pcs_pkg::IDX_PC_LATCH: reg_rdata = {25'h000_0000, latch_q};
      pcs_pkg::IDX_STACK_POINTER: reg_rdata = {27'h000_0000, sp_q};
      pcs_pkg::IDX_TOS_LOW: reg_rdata = {24'h00_0000, tos[7:0]};
      pcs_pkg::IDX_TOS_HIGH: reg_rdata = {25'h000_0000, tos[14:8]};
      default: reg_rdata = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  pcs_stack_mem #(
    .DEPTH(pcs_pkg::STK_DEPTH),
    .WIDTH(pcs_pkg::PC_W),
    .AW(pcs_pkg::STK_AW)
  ) u_mem (
    .clock(clock),
    .reset(reset),
    .ce(ce),
    .we(stk_we),
    .waddr(stk_waddr),
    .wdata(stk_wdata),
    .raddr(sp_d[3:0]),
    .rdata(tos)
  );

  pcs_avmm_port u_port (
    .clock(clock),
    .reset(reset),
    .ce(ce),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest),
    .avs_readdata(avs_readdata),
    .reg_rdata(reg_rdata),
    .reg_wr_fire(wr_fire)
  );

  ////////////////////////////////////////////////////////////////////////////////
  assign pc = pc_q;
  assign pc_high_latch = latch_q;
  assign stack_pointer = sp_q;
  assign stack_overflow_flag = ovf_q;
  assign stack_underflow_flag = unf_q;
  assign stack_fault_reset = fault_q;
endmodule : pcs_core

// >>> bench/pcs_core_asserts.sv
`timescale 1ns/1ps
module pcs_core_asserts (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  input wire logic ce,
  // core requests
  input wire pcs_pkg::pcs_op_t op,
  input wire logic [10:0] op_operand,
  input wire logic [7:0] working,
  input wire logic [7:0] pcl_wdata,
  input wire logic latch_we,
  input wire logic avs_write,
  // visible state
  input wire logic [14:0] pc,
  input wire logic [6:0] pc_high_latch,
  input wire logic [4:0] stack_pointer,
  input wire logic stack_overflow_flag,
  input wire logic stack_underflow_flag,
  input wire logic stack_fault_reset
);
  logic is_push;
  logic is_pop;
  logic fault_cause;
  assign is_push = ce && (op == pcs_pkg::PCS_OP_CALL || op == pcs_pkg::PCS_OP_INTERRUPT
    || op == pcs_pkg::PCS_OP_CALL_VIA_WORKING);
  assign is_pop = ce && op == pcs_pkg::PCS_OP_RETURN;
  // pulse stands in the cycle after the edge that took its cause
  assign fault_cause = (is_push && stack_pointer == 5'h0f) || (is_pop && stack_pointer == 5'h1f);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  sequence s_push;
    is_push;
  endsequence
  sequence s_pop;
    is_pop;
  endsequence
  sequence s_op(pcs_pkg::pcs_op_t k);
    ce && op == k;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  a_pcl_load_whole: assert property (
    s_op(pcs_pkg::PCS_OP_PCL_WRITE) |=> pc == {$past(pc_high_latch), $past(pcl_wdata)})
    else $error("pc low write did not load all 15 bits");
  a_call_target: assert property (
    s_op(pcs_pkg::PCS_OP_CALL) |=> pc == {$past(pc_high_latch[6:3]), $past(op_operand)})
    else $error("call target wrong");
  a_call_via_working_target: assert property (
    s_op(pcs_pkg::PCS_OP_CALL_VIA_WORKING) |=> pc == {$past(pc_high_latch), $past(working)})
    else $error("call via working target wrong");
  a_brw_target: assert property (
    s_op(pcs_pkg::PCS_OP_BRANCH_RELATIVE_WORKING)
    |=> pc == $past(pc) + 15'h0001 + {7'h00, $past(working)})
    else $error("working branch target wrong");
  a_bra_target: assert property (
    s_op(pcs_pkg::PCS_OP_BRANCH_RELATIVE_LITERAL)
    |=> pc == $past(pc) + 15'h0001 + {{6{$past(op_operand[8])}}, $past(op_operand[8:0])})
    else $error("literal branch target wrong");
  a_push_incr: assert property (
    s_push |=> stack_pointer == $past(stack_pointer) + 5'h01)
    else $error("push did not advance pointer by one");
  a_pop_decr: assert property (
    s_pop |=> stack_pointer == $past(stack_pointer) - 5'h01)
    else $error("pop did not step pointer back by one");
  a_latch_untouched: assert property (
    (is_push || is_pop) && !latch_we && !avs_write |=> $stable(pc_high_latch))
    else $error("push or pop changed the high latch");
  a_overflow_flag: assert property (
    s_push ##0 stack_pointer == 5'h0f |=> stack_overflow_flag)
    else $error("overflow flag not set");
  a_underflow_flag: assert property (
    s_pop ##0 stack_pointer == 5'h1f |=> stack_underflow_flag)
    else $error("underflow flag not set");
  a_fault_cause: assert property (
    stack_fault_reset |-> $past(fault_cause))
    else $error("fault reset pulse without a stack fault");
  a_reset_state: assert property (
    $fell(reset) |-> pc == 15'h0000 && stack_pointer == 5'h1f)
    else $error("state after reset wrong");
endmodule : pcs_core_asserts

bind pcs_core pcs_core_asserts u_pcs_asserts (
  .clock(clock), .reset(reset), .ce(ce), .op(op), .op_operand(op_operand),
  .working(working), .pcl_wdata(pcl_wdata), .latch_we(latch_we), .avs_write(avs_write),
  .pc(pc), .pc_high_latch(pc_high_latch), .stack_pointer(stack_pointer),
  .stack_overflow_flag(stack_overflow_flag), .stack_underflow_flag(stack_underflow_flag),
  .stack_fault_reset(stack_fault_reset)
);

// >>> bench/pcs_core_model.sv
`timescale 1ns/1ps
module pcs_core_model (
  // clock
  input wire logic clock,
  // execution requests
  output pcs_pkg::pcs_op_t op,
  output logic [10:0] op_operand,
  output logic [7:0] working,
  output logic [7:0] pcl_wdata,
  output logic latch_we,
  output logic [6:0] latch_wdata
);
  // latch is loaded over the bus here, so the direct strobe stays idle
  initial begin
    op = pcs_pkg::PCS_OP_NONE;
    op_operand = 11'h000;
    working = 8'h00;
    pcl_wdata = 8'h00;
    latch_we = 1'b0;
    latch_wdata = 7'h00;
  end
  // one op for one edge, then idle; never runs while software moves the pointer
  task automatic issue(input pcs_pkg::pcs_op_t o, input logic [10:0] a, input logic [7:0] w);
    @(posedge clock);
    op <= o;
    op_operand <= a;
    working <= w;
    pcl_wdata <= a[7:0];
    @(posedge clock);
    op <= pcs_pkg::PCS_OP_NONE;
  endtask : issue
endmodule : pcs_core_model

// >>> bench/test_program_counter_and_stack.sv
`timescale 1ns/1ps
module test_program_counter_and_stack;
  logic clock, reset, power_on_reset, ce = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [13:0] avs_address = 14'h0000;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [3:0] avs_byteenable = 4'hf;
  pcs_pkg::pcs_op_t op;
  logic [10:0] op_operand;
  logic [7:0] working, pcl_wdata;
  logic [6:0] latch_wdata, pc_high_latch, lat = 7'h00;
  logic latch_we, avs_waitrequest, stack_overflow_flag, stack_underflow_flag, stack_fault_reset;
  logic [14:0] pc, exp_pc, stk [16];
  logic [4:0] stack_pointer, exp_sp;
  logic ovf = 1'b0, unf = 1'b0;
  int errors = 0, checks_done = 0, cycles = 0;
  pcs_core #(.INT_VECTOR(15'h0004)) DUT (
    .clock(clock), .reset(reset), .ce(ce), .power_on_reset(power_on_reset), .op(op),
    .op_operand(op_operand), .working(working), .pcl_wdata(pcl_wdata), .latch_we(latch_we),
    .latch_wdata(latch_wdata), .pc(pc), .pc_high_latch(pc_high_latch),
    .stack_pointer(stack_pointer), .stack_overflow_flag(stack_overflow_flag),
    .stack_underflow_flag(stack_underflow_flag), .stack_fault_reset(stack_fault_reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest)
  );
  pcs_core_model u_core (
    .clock(clock), .op(op), .op_operand(op_operand), .working(working),
    .pcl_wdata(pcl_wdata), .latch_we(latch_we), .latch_wdata(latch_wdata)
  );
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : check
  // holds the request until waitrequest is seen low; only the bench timeout ends a stuck wait
  task automatic bus(input logic w, input logic [11:0] idx, input logic [7:0] d);
    @(posedge clock);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic rdchk(input string n, input logic [11:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    check(n, {24'h0, e}, rd);
  endtask : rdchk
  task automatic do_reset(input logic por);
    reset <= 1'b1;
    power_on_reset <= por;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    power_on_reset <= 1'b0;
    exp_pc = 15'h0000;
    exp_sp = 5'h1f;
    #1;
  endtask : do_reset
  task automatic push(input logic [14:0] v);
    if (exp_sp == 5'h0f) ovf = 1'b1;
    exp_sp = exp_sp + 5'h01;
    stk[exp_sp[3:0]] = v;
  endtask : push
  task automatic step(input pcs_pkg::pcs_op_t o, input logic [10:0] a, input logic [7:0] w);
    u_core.issue(o, a, w);
    #1;
    // with the clock enable low the op is not taken at all
    if (ce !== 1'b1) o = pcs_pkg::PCS_OP_NONE;
    case (o)
      pcs_pkg::PCS_OP_STEP: exp_pc = exp_pc + 15'h0001;
      pcs_pkg::PCS_OP_PCL_WRITE: exp_pc = {lat, a[7:0]};
      pcs_pkg::PCS_OP_CALL: begin
        push(exp_pc + 15'h0001);
        exp_pc = {lat[6:3], a};
      end
      pcs_pkg::PCS_OP_CALL_VIA_WORKING: begin
        push(exp_pc + 15'h0001);
        exp_pc = {lat, w};
      end
      pcs_pkg::PCS_OP_INTERRUPT: begin
        push(exp_pc);
        exp_pc = 15'h0004;
      end
      pcs_pkg::PCS_OP_BRANCH_RELATIVE_WORKING: exp_pc = exp_pc + 15'h0001 + {7'h00, w};
      pcs_pkg::PCS_OP_BRANCH_RELATIVE_LITERAL: exp_pc = exp_pc + 15'h0001 + {{6{a[8]}}, a[8:0]};
      pcs_pkg::PCS_OP_RETURN: begin
        if (exp_sp == 5'h1f) unf = 1'b1;
        exp_pc = stk[exp_sp[3:0]];
        exp_sp = exp_sp - 5'h01;
      end
      default: exp_pc = exp_pc;
    endcase
    check("pc", 32'(exp_pc), 32'(pc));
    check("stack_pointer", 32'(exp_sp), 32'(stack_pointer));
    check("flags", 32'({ovf, unf}), 32'({stack_overflow_flag, stack_underflow_flag}));
  endtask : step
  // the pulse stands only in the cycle right after the faulting op
  task automatic fault_chk(input logic e);
    check("stack_fault_reset", 32'(e), 32'(stack_fault_reset));
  endtask : fault_chk
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    reset = 1'b1;
    power_on_reset = 1'b1;
    do_reset(1'b1);
    check("pc", 32'(exp_pc), 32'(pc));
    rdchk("stack_pointer", 12'hfed, 8'h1f);
    bus(1'b1, 12'hfe3, 8'h15);
    lat = 7'h15;
    step(pcs_pkg::PCS_OP_PCL_WRITE, 11'h0ab, 8'h00);
    rdchk("pc_low_byte", 12'hfe2, 8'hab);
    step(pcs_pkg::PCS_OP_CALL, 11'h123, 8'h00);
    step(pcs_pkg::PCS_OP_CALL_VIA_WORKING, 11'h000, 8'h5c);
    step(pcs_pkg::PCS_OP_INTERRUPT, 11'h000, 8'h00);
    rdchk("pc_high_latch", 12'hfe3, 8'h15);
    rdchk("top_of_stack_low", 12'hfee, stk[2][7:0]);
    rdchk("top_of_stack_high", 12'hfef, {1'b0, stk[2][14:8]});
    step(pcs_pkg::PCS_OP_BRANCH_RELATIVE_WORKING, 11'h000, 8'hff);
    step(pcs_pkg::PCS_OP_BRANCH_RELATIVE_LITERAL, 11'h1f0, 8'h00);
    step(pcs_pkg::PCS_OP_BRANCH_RELATIVE_LITERAL, 11'h011, 8'h00);
    repeat (3) step(pcs_pkg::PCS_OP_RETURN, 11'h000, 8'h00);
    bus(1'b1, 12'hfed, 8'h0f);
    bus(1'b1, 12'hfee, 8'h34);
    bus(1'b1, 12'hfef, 8'h12);
    bus(1'b1, 12'hfed, 8'h1f);
    stk[15] = 15'h1234;
    step(pcs_pkg::PCS_OP_RETURN, 11'h000, 8'h00);
    fault_chk(1'b0);
    rdchk("status", 12'hfe0, 8'h02);
    bus(1'b1, 12'hfe0, 8'h02);
    unf = 1'b0;
    rdchk("status", 12'hfe0, 8'h00);
    bus(1'b1, 12'hfed, 8'h1f);
    exp_sp = 5'h1f;
    for (int i = 0; i < 17; i++) step(pcs_pkg::PCS_OP_CALL, 11'(i * 40 + 5), 8'h00);
    rdchk("top_of_stack_low", 12'hfee, stk[0][7:0]);
    rdchk("status", 12'hfe0, 8'h01);
    bus(1'b1, 12'hfe1, 8'h01);
    bus(1'b1, 12'hfed, 8'h1f);
    exp_sp = 5'h1f;
    step(pcs_pkg::PCS_OP_RETURN, 11'h000, 8'h00);
    fault_chk(1'b1);
    rdchk("unmapped", 12'hfec, 8'h00);
    do_reset(1'b0);
    check("pc", 32'(exp_pc), 32'(pc));
    rdchk("stack_pointer", 12'hfed, 8'h1f);
    rdchk("status", 12'hfe0, 8'h03);
    step(pcs_pkg::PCS_OP_STEP, 11'h000, 8'h00);
    @(posedge clock);
    ce <= 1'b0;
    step(pcs_pkg::PCS_OP_CALL, 11'h0aa, 8'h00);
    @(posedge clock);
    ce <= 1'b1;
    step(pcs_pkg::PCS_OP_STEP, 11'h000, 8'h00);
    end_of_test();
  end
endmodule : test_program_counter_and_stack
